// ===== bench/epid_pin_src.sv
// Purpose: model of the sources driving the interrupt pins
// Assumes: one clock, pins start idle high on the dedicated side
// Notes: wanted levels are taken every other cycle only
`timescale 1ns/1ns
`default_nettype none
module epid_pin_src (
   input wire logic clk_i,
   input wire logic [7:0] port_want_i,
   input wire logic [1:0] ext_want_i,
   output logic [7:0] port_o,
   output logic [1:0] ext_o
);
   logic turn_q;
   initial begin
      turn_q = 1'b0;
      port_o = 8'h00;
      ext_o = 2'b11;
   end
   always @(posedge clk_i) begin
      turn_q <= ~turn_q;
      if (turn_q) begin
         port_o <= port_want_i;
         ext_o <= ext_want_i;
      end
   end
endmodule
`default_nettype wire

// ===== bench/test_epid_top.sv
// Purpose: self-checking bench of the pin interrupt block
// Assumes: one bus master, reads scored through a queue
// Notes: a cycle ceiling ends a hang
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_epid_top;
   import epid_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
   logic [AW-1:0] adr = '0;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = '0, dat_o;
   logic ack, ppi, wake, irq;
   logic [1:0] ext_ack = 2'b00, ext_req, ext_pin, ext_want = 2'b11;
   logic [7:0] port_pin, port_want = 8'h00, exp_v, v, act;
   logic [7:0] exp_q[$];
   logic [31:0] seed = 32'd98780;
   int err_total = 0, tests_run = 0, cyc_cnt = 0, wake_cnt = 0;
   always #25 clk_i = ~clk_i;
   epid_pin_src src_u (.clk_i(clk_i), .port_want_i(port_want),
      .ext_want_i(ext_want), .port_o(port_pin), .ext_o(ext_pin));
   epid_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .ext_irq_pin_i(ext_pin), .port_pin_i(port_pin), .ext_ack_i(ext_ack),
      .ext_request_o(ext_req), .port_pin_interrupt_o(ppi), .wake_o(wake),
      .irq_o(irq));
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic rw(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'h1;
      adr <= {2'b00, idx, 2'b00};
      dat <= {24'h0, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      exp_q.push_back(e);
      rw(1'b0, idx, 8'h00);
   endtask
   task automatic give_verdict();
      $display("errors %0d of %0d checks", err_total, tests_run);
      if (err_total == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // read data scored against the oldest note
   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0) begin
         exp_v = exp_q.pop_front();
         `CHK(dat_o, {24'h0, exp_v})
      end
      if (wake === 1'b1) wake_cnt++;
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         err_total++;
         give_verdict();
      end
   end
   initial begin
      tick(8);
      rst_i <= 1'b0;
      tick(3);
      for (int i = 0; i < 4; i++) rd(IDX_MODE + i, 8'h00);
      rd(8'hff, 8'h00);
      for (int i = 0; i < 3; i++) begin
         v = rnd();
         rw(1'b1, IDX_MODE + i, v);
         rd(IDX_MODE + i, v);
      end
      rw(1'b1, IDX_EN, 8'h00);
      for (int i = 0; i < 4; i++) begin
         act = {8{i[0]}};
         rw(1'b1, IDX_MODE, {8{i[1]}});
         rw(1'b1, IDX_POL, act);
         port_want <= ~act;
         tick(8);
         rw(1'b1, IDX_FLAGS, 8'h00);
         v = rnd() | 8'h01;
         rw(1'b1, IDX_EN, v);
         rd(IDX_FLAGS, 8'h00);
         port_want <= act;
         tick(8);
         rd(IDX_FLAGS, v);
         @(negedge clk_i);
         `CHK(ppi, 1'b1)
         port_want <= ~act;
         tick(8);
         rd(IDX_FLAGS, v);
         rw(1'b1, IDX_FLAGS, 8'h00);
         rw(1'b1, IDX_EN, 8'h00);
      end
      @(negedge clk_i);
      `CHK(irq, 1'b0)
      rw(1'b1, IDX_MASK, 8'h04);
      @(negedge clk_i);
      `CHK(irq, 1'b1)
      rw(1'b1, IDX_STAT, 8'h0f);
      @(negedge clk_i);
      `CHK(irq, 1'b0)
      rw(1'b1, IDX_EXT, 8'h00);
      ext_want <= 2'b00;
      tick(6);
      @(negedge clk_i);
      `CHK(ext_req, 2'b11)
      tick(1);
      ext_want <= 2'b11;
      tick(6);
      rw(1'b1, IDX_EXT, 8'h03);
      ext_want <= 2'b00;
      tick(8);
      rd(IDX_EXT, 8'h0f);
      ext_want <= 2'b11;
      ext_ack <= 2'b01;
      tick(1);
      ext_ack <= 2'b00;
      @(negedge clk_i);
      `CHK(ext_req, 2'b10)
      rw(1'b1, IDX_EXT, 8'h00);
      rw(1'b1, IDX_STAT, 8'h0f);
      rw(1'b1, IDX_PWR, 8'h01);
      rd(IDX_PWR, 8'h01);
      ext_want <= 2'b10;
      tick(8);
      rd(IDX_PWR, 8'h00);
      `CHK(wake_cnt, 1)
      ext_want <= 2'b11;
      rw(1'b1, IDX_MODE, 8'h00);
      rw(1'b1, IDX_EN, 8'h01);
      rw(1'b1, IDX_PWR, 8'h01);
      port_want <= 8'h01;
      tick(8);
      rd(IDX_PWR, 8'h00);
      `CHK(wake_cnt, 2)
      tick(2);
      give_verdict();
   end
endmodule
`default_nettype wire

// ===== core/epid_pin_sample.sv
// Purpose: brings one pin into the clock domain and keeps its history
// Assumes: pin is asynchronous to clk_i
// Notes: smp_o is the current sample, prev_o the sample before it
`timescale 1ns/1ns
`default_nettype none
module epid_pin_sample (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pin_i,
   output logic smp_o,
   output logic prev_o
);
   logic meta_q;
   logic smp_q;
   logic prev_q;

   // reset to high so an idle pin raises no edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= 1'b1;
         smp_q <= 1'b1;
         prev_q <= 1'b1;
      end else begin
         meta_q <= pin_i;
         smp_q <= meta_q;
         prev_q <= smp_q;
      end
   end

   assign smp_o = smp_q;
   assign prev_o = prev_q;
endmodule
`default_nettype wire

// ===== core/epid_pkg.sv
// Purpose: constants for the external pin interrupt detect block
// Assumes: 20 MHz clock, classic Wishbone with 32-bit data words
// Notes: register indices are word indices on the bus
// Summary of operation
// - low trigger type: low sample requests
// - edge type: high then low sets flag
// - edge flag clears when handler vectors
// - dedicated pins wake from power-down
// - eight configurable port pin interrupts
// - enable bit gates port pin flag
// - mode bit: level zero, edge one
// - polarity: low/falling zero, high/rising one
// - level needs two equal consecutive samples
// - edge seen when consecutive samples differ
// - port flags sticky, software clears only
// - any port pin interrupt wakes device
// - four port registers reset to zero
`default_nettype none
package epid_pkg;
   localparam int unsigned N_GP = 8;
   localparam int unsigned N_EXT = 2;
   localparam int unsigned DW = 8;
   localparam int unsigned AW = 12;
   // timing of the pins as seen by the sampler
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned MIN_HOLD_NS = 100;
   localparam int unsigned MIN_HOLD_CYC =
      (MIN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_MODE = 8'h9a;
   localparam logic [7:0] IDX_POL = 8'h9b;
   localparam logic [7:0] IDX_EN = 8'h9c;
   localparam logic [7:0] IDX_FLAGS = 8'h9d;
   localparam logic [7:0] IDX_EXT = 8'ha0;
   localparam logic [7:0] IDX_STAT = 8'ha1;
   localparam logic [7:0] IDX_MASK = 8'ha2;
   localparam logic [7:0] IDX_PWR = 8'ha3;
   localparam logic [7:0] RST_REG = 8'h00;
   // dedicated interrupt control register fields
   localparam int unsigned EXT_TRIG_LSB = 0;
   localparam int unsigned EXT_FLAG_LSB = 2;
   // status and mask fields
   localparam int unsigned ST_W = 4;
   localparam int unsigned ST_EXT0 = 0;
   localparam int unsigned ST_EXT1 = 1;
   localparam int unsigned ST_GPI = 2;
   localparam int unsigned ST_WAKE = 3;
   localparam int unsigned PWR_PD_BIT = 0;
endpackage
`default_nettype wire

// ===== core/epid_top.sv
// Purpose: dedicated and port pin interrupt detection with register file
// Assumes: classic Wishbone slave, 8-bit registers in the low data lane
// Notes: ext_ack_i pulses when the processor vectors to a dedicated handler
`timescale 1ns/1ns
`default_nettype none
module epid_top
   import epid_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [N_EXT-1:0] ext_irq_pin_i,
   input wire logic [N_GP-1:0] port_pin_i,
   input wire logic [N_EXT-1:0] ext_ack_i,
   output logic [N_EXT-1:0] ext_request_o,
   output logic port_pin_interrupt_o,
   output logic wake_o,
   output logic irq_o
);
   // register state
   logic [DW-1:0] mode_q;
   logic [DW-1:0] pol_q;
   logic [DW-1:0] en_q;
   logic [DW-1:0] flags_q;
   logic [DW-1:0] flags_d;
   logic [N_EXT-1:0] trig_q;
   logic [N_EXT-1:0] ext_flag_q;
   logic [N_EXT-1:0] ext_flag_d;
   logic [ST_W-1:0] stat_q;
   logic [ST_W-1:0] stat_d;
   logic [ST_W-1:0] mask_q;
   logic pd_q;
   logic wake_q;
   logic ack_q;
   logic [DW-1:0] rdat_q;
   logic [N_EXT-1:0] req_prev_q;

   // sampled pins
   logic [N_GP-1:0] gp_smp;
   logic [N_GP-1:0] gp_prev;
   logic [N_EXT-1:0] ext_smp;
   logic [N_EXT-1:0] ext_prev;

   genvar g;
   generate
      for (g = 0; g < N_GP; g = g + 1) begin : g_gp
         epid_pin_sample u_smp (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .pin_i(port_pin_i[g]),
            .smp_o(gp_smp[g]),
            .prev_o(gp_prev[g])
         );
      end
      for (g = 0; g < N_EXT; g = g + 1) begin : g_ext
         epid_pin_sample u_smp (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .pin_i(ext_irq_pin_i[g]),
            .smp_o(ext_smp[g]),
            .prev_o(ext_prev[g])
         );
      end
   endgenerate

   // bus decode
   wire bus_req = wb_cyc_i & wb_stb_i;
   wire [7:0] idx = wb_adr_i[9:2];
   wire hi_zero = (wb_adr_i[AW-1:10] == '0);
   wire lane0 = wb_sel_i[0];
   wire wr_go = bus_req & wb_we_i & ack_q & lane0 & hi_zero;
   wire wr_mode = wr_go & (idx == IDX_MODE);
   wire wr_pol = wr_go & (idx == IDX_POL);
   wire wr_en = wr_go & (idx == IDX_EN);
   wire wr_flags = wr_go & (idx == IDX_FLAGS);
   wire wr_ext = wr_go & (idx == IDX_EXT);
   wire wr_stat = wr_go & (idx == IDX_STAT);
   wire wr_mask = wr_go & (idx == IDX_MASK);
   wire wr_pwr = wr_go & (idx == IDX_PWR);
   wire [DW-1:0] wdat = wb_dat_i[DW-1:0];

   // port pin detection
   // polarity match
   wire [N_GP-1:0] lvl_now = ~(gp_smp ^ pol_q);
   wire [N_GP-1:0] lvl_old = ~(gp_prev ^ pol_q);
   wire [N_GP-1:0] lvl_hit = lvl_now & lvl_old;
   // change between samples in chosen direction
   wire [N_GP-1:0] edge_hit = (gp_smp ^ gp_prev) & lvl_now;
   wire [N_GP-1:0] cond = (mode_q & edge_hit) | (~mode_q & lvl_hit);
   // only enabled pins raise a flag
   wire [N_GP-1:0] gp_set = cond & en_q;

   // set wins, only a software write can clear
   always_comb begin
      flags_d = wr_flags ? wdat : flags_q;
      flags_d = flags_d | gp_set;
   end

   // dedicated pin detection
   // high sample followed by low sample
   wire [N_EXT-1:0] ext_edge = ext_prev & ~ext_smp & trig_q;
   // handler entry clears edge flag, new edge wins
   always_comb begin
      ext_flag_d = wr_ext ? wdat[EXT_FLAG_LSB +: N_EXT] : ext_flag_q;
      ext_flag_d = (ext_flag_d & ~(ext_ack_i & trig_q)) | ext_edge;
   end
   // low level requests when trigger type is zero
   wire [N_EXT-1:0] ext_req = (trig_q & ext_flag_q) | (~trig_q & ~ext_smp);

   // interrupt status events
   wire [N_EXT-1:0] ext_rise = ext_req & ~req_prev_q;
   // any dedicated request or port flag ends power-down
   wire wake_src = (|ext_req) | (|flags_q);
   wire wake_ev = pd_q & wake_src;
   wire [ST_W-1:0] stat_set = {wake_ev, |gp_set, ext_rise[1], ext_rise[0]};

   always_comb begin
      stat_d = wr_stat ? (stat_q & ~wdat[ST_W-1:0]) : stat_q;
      stat_d = stat_d | stat_set;
   end

   // read mux
   logic [DW-1:0] rmux;
   always_comb begin
      rmux = RST_REG;
      if (hi_zero) begin
         unique case (idx)
            IDX_MODE: rmux = mode_q;
            IDX_POL: rmux = pol_q;
            IDX_EN: rmux = en_q;
            IDX_FLAGS: rmux = flags_q;
            IDX_EXT: begin
               rmux[EXT_TRIG_LSB +: N_EXT] = trig_q;
               rmux[EXT_FLAG_LSB +: N_EXT] = ext_flag_q;
            end
            IDX_STAT: rmux[ST_W-1:0] = stat_q;
            IDX_MASK: rmux[ST_W-1:0] = mask_q;
            IDX_PWR: rmux[PWR_PD_BIT] = pd_q;
            default: rmux = RST_REG;
         endcase
      end
   end

   // bus answer one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdat_q <= RST_REG;
      end else begin
         ack_q <= bus_req & ~ack_q;
         if (bus_req & ~ack_q) begin
            rdat_q <= rmux;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_q <= RST_REG;
         pol_q <= RST_REG;
         en_q <= RST_REG;
         flags_q <= RST_REG;
      end else begin
         if (wr_mode) begin
            mode_q <= wdat;
         end
         if (wr_pol) begin
            pol_q <= wdat;
         end
         if (wr_en) begin
            en_q <= wdat;
         end
         flags_q <= flags_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trig_q <= '0;
         ext_flag_q <= '0;
         req_prev_q <= '0;
         stat_q <= '0;
         mask_q <= '0;
      end else begin
         if (wr_ext) begin
            trig_q <= wdat[EXT_TRIG_LSB +: N_EXT];
         end
         ext_flag_q <= ext_flag_d;
         req_prev_q <= ext_req;
         stat_q <= stat_d;
         if (wr_mask) begin
            mask_q <= wdat[ST_W-1:0];
         end
      end
   end

   // power-down: software sets, a wake source clears
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pd_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         wake_q <= wake_ev;
         if (wake_ev) begin
            pd_q <= 1'b0;
         end else if (wr_pwr) begin
            pd_q <= wdat[PWR_PD_BIT];
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = {{(32-DW){1'b0}}, rdat_q};
   assign ext_request_o = ext_req;
   assign port_pin_interrupt_o = |flags_q;
   assign wake_o = wake_q;
   assign irq_o = |(stat_q & mask_q);

   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_ext_level_req: assert property (
      (!trig_q[0] && !ext_smp[0]) |-> ext_request_o[0])
      else $error("low level did not request");

   a_ext_edge_set: assert property (
      (trig_q[1] && ext_prev[1] && !ext_smp[1]) |=> ext_flag_q[1] ##0
      ext_request_o[1])
      else $error("falling edge did not set flag");

   a_ext_ack_clear: assert property (
      (trig_q[0] && ext_ack_i[0] && !ext_edge[0] && !wr_ext)
      |=> !ext_flag_q[0])
      else $error("edge flag not cleared on vector");

   a_gp_enable_gate: assert property (
      (!en_q[0] && !wr_flags && !flags_q[0]) |=> !flags_q[0])
      else $error("disabled pin raised flag");

   a_gp_level_two: assert property (
      (en_q[2] && !mode_q[2] && gp_smp[2] == pol_q[2] &&
      gp_prev[2] == pol_q[2]) |=> flags_q[2])
      else $error("steady level not flagged");

   a_gp_level_one: assert property (
      (!mode_q[3] && gp_prev[3] != pol_q[3] && !wr_flags &&
      !flags_q[3]) |=> !flags_q[3])
      else $error("single sample flagged in level mode");

   a_gp_edge_dir: assert property (
      (en_q[1] && mode_q[1] && gp_smp[1] != gp_prev[1] &&
      gp_smp[1] == pol_q[1]) |=> flags_q[1])
      else $error("edge not flagged");

   a_gp_sticky: assert property (
      (flags_q[4] && !wr_flags) |=> flags_q[4])
      else $error("flag cleared without software");

   a_gp_reset_zero: assert property (
      $fell(rst_i) |-> (mode_q == '0 && pol_q == '0 &&
      en_q == '0 && flags_q == '0))
      else $error("port registers not zero after reset");

   a_gp_combined: assert property (
      $rose(flags_q[5]) |-> port_pin_interrupt_o)
      else $error("combined request missing");

   a_wake_exit: assert property (
      (pd_q && |flags_q) |=> (!pd_q && wake_o) ##1 !wake_o)
      else $error("port flag did not wake");

   a_irq_level: assert property (
      (stat_q[ST_GPI] && mask_q[ST_GPI]) |-> irq_o)
      else $error("unmasked status did not interrupt");

   a_bus_ack: assert property (
      $rose(bus_req) |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer not one cycle");

   a_bus_hi_zero: assert property (
      wb_dat_o[31:DW] == '0)
      else $error("upper read lanes not zero");

   a_ext_level_off: assert property (
      (!trig_q[1] && ext_smp[1]) |-> !ext_request_o[1])
      else $error("high level still requested");

   a_ext_edge_hold: assert property (
      (trig_q[1] && ext_flag_q[1] && !ext_ack_i[1] && !wr_ext)
      |=> ext_flag_q[1])
      else $error("edge flag lost without vector");

   a_ext_wake: assert property (
      (pd_q && |ext_request_o) |=> (!pd_q && wake_o))
      else $error("dedicated request did not wake");

   a_ext_reset_zero: assert property (
      $fell(rst_i) |-> (trig_q == '0 && ext_flag_q == '0 &&
      stat_q == '0 && mask_q == '0 && !pd_q))
      else $error("control registers not zero after reset");

   // each pin flags an edge in its chosen direction
   for (g = 0; g < N_GP; g = g + 1) begin : g_chk
      a_gp_edge_each: assert property (
         (en_q[g] && mode_q[g] && gp_smp[g] != gp_prev[g] &&
         gp_smp[g] == pol_q[g]) |=> flags_q[g])
         else $error("pin edge not flagged");
   end

   a_gp_edge_wrong: assert property (
      (mode_q[6] && gp_smp[6] != pol_q[6] && !wr_flags &&
      !flags_q[6]) |=> !flags_q[6])
      else $error("edge of wrong direction flagged");

   a_gp_edge_still: assert property (
      (mode_q[0] && gp_smp[0] == gp_prev[0] && !wr_flags &&
      !flags_q[0]) |=> !flags_q[0])
      else $error("steady pin flagged in edge mode");

   a_gp_soft_clear: assert property (
      (wr_flags && !wdat[4] && !gp_set[4]) |=> !flags_q[4])
      else $error("software clear of flag ignored");

   a_stat_sticky: assert property (
      (stat_q[ST_GPI] && !wr_stat) |=> stat_q[ST_GPI])
      else $error("status bit lost without write");

   a_irq_quiet: assert property (
      ((stat_q & mask_q) == '0) |-> !irq_o)
      else $error("interrupt without unmasked status");

   a_wake_pulse: assert property (
      wake_o |=> !wake_o)
      else $error("wake pulse longer than one cycle");
endmodule
`default_nettype wire
